// ===== core/nvmac_ctrl.sv
// Purpose: Register side of the data EEPROM and program flash access path.
// Assumes: Core writes and reads special function registers with one-cycle strobes.
// Notes: Arrays are modelled as flip-flops; flash row erase clears a 32-word row.
// Functional notes
// - 256-byte data space, low address only
// - Flash word 14 bits, address 13 bits
// - Flash 4K words, upper addresses wrap
// - Unimplemented data address: no programming
// - Data byte write erases then programs
// - Flash single reads, erase then 4-word writes
// - Internal timer ends data, row erase and last-word flash writes
// - Core access unaffected by code protection
// - Bit 7 selects program or data space
// - Read and write starts set-only, hardware clears
// - Write permit cleared by hard reset or software write, gates writes
// - Interrupting reset sets abort, keeps registers
// - Write done flag sticky until software clears
// - Key port stores nothing, reads zero
// - Bit 4 turns a program space write into row erase
// - Bits 6 and 5 read zero
// - Read data appears on the next cycle
// - Write needs 55h then AAh first
// - Start refused without permit; clearing later harmless
// - Done flag at bit 4 of flags two
`include "nvmac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module nvmac_ctrl (
	input wire logic clock,
	input wire logic rstn,
	input wire logic soft_reset_event,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [8:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic core_stall,
	output logic pump_on
);
	// Write timing: a short cycle count so the core stall stays short in simulation.
	localparam int WRITE_CYCLES = `NVMAC_WRITE_CYCLES;
	localparam int PROG_WORDS = 4096;

	logic [7:0] data_mem [0:255];
	logic [13:0] prog_mem [0:PROG_WORDS-1];
	logic [13:0] prog_buf [0:3];
	logic [7:0] data_low, data_high, addr_low, addr_high;
	logic space, row_erase, abort, permit, wr_bit, rd_bit, done_flag;
	logic [15:0] timer;
	nvmac_pkg::nvmac_key_t key_state;
	nvmac_pkg::nvmac_eng_t eng_state;

	function automatic logic hit(input logic [8:0] a, input logic [8:0] r);
		hit = reg_wr && (a == r);
	endfunction

	wire wr_ctrl = hit(reg_addr, `NVMAC_ADDR_CONTROL);
	wire wr_key = hit(reg_addr, `NVMAC_ADDR_KEY);
	wire [12:0] full_addr = {addr_high[4:0], addr_low};
	wire [11:0] prog_addr = full_addr[11:0];
	wire data_addr_ok = 1'b1; // all 256 byte addresses are implemented
	wire start_rd = wr_ctrl && reg_wdata[`NVMAC_BIT_RD] && !rd_bit;
	wire start_wr = wr_ctrl && reg_wdata[`NVMAC_BIT_WR] && !wr_bit && permit && key_state == nvmac_pkg::KEY_ARMED;
	wire wr_long = space ? (row_erase || prog_addr[1:0] == 2'h3) : 1'b1;
	wire [7:0] ctrl_view = {space, 2'h0, row_erase, abort, permit, wr_bit, rd_bit};

	// Unlock tracker; any other register write drops it back to idle.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			key_state <= nvmac_pkg::KEY_IDLE;
		end else if (reg_wr) begin
			unique case (key_state)
				nvmac_pkg::KEY_IDLE: key_state <= (wr_key && reg_wdata == `NVMAC_KEY_FIRST) ? nvmac_pkg::KEY_GOT_FIRST : nvmac_pkg::KEY_IDLE;
				nvmac_pkg::KEY_GOT_FIRST: key_state <= (wr_key && reg_wdata == `NVMAC_KEY_SECOND) ? nvmac_pkg::KEY_ARMED : nvmac_pkg::KEY_IDLE;
				nvmac_pkg::KEY_ARMED: key_state <= nvmac_pkg::KEY_IDLE;
			endcase
		end
	end

	// Control bits; abort and permit survive the soft reset input, the rest is cleared by it.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			space <= 1'b0;
			row_erase <= 1'b0;
			abort <= 1'b0;
			permit <= 1'b0;
		end else if (soft_reset_event) begin
			space <= 1'b0;
			row_erase <= 1'b0;
			if (eng_state != nvmac_pkg::ENG_IDLE) begin
				abort <= 1'b1;
			end
		end else if (wr_ctrl) begin
			space <= reg_wdata[`NVMAC_BIT_SPACE];
			row_erase <= reg_wdata[`NVMAC_BIT_ROW_ERASE];
			abort <= reg_wdata[`NVMAC_BIT_ABORT];
			permit <= reg_wdata[`NVMAC_BIT_PERMIT];
		end
	end

	// Write engine with its own timer; the core stalls for a full cycle of a timed program-space write only.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			eng_state <= nvmac_pkg::ENG_IDLE;
			timer <= 16'h0000;
			wr_bit <= 1'b0;
		end else if (soft_reset_event) begin
			eng_state <= nvmac_pkg::ENG_IDLE;
			wr_bit <= 1'b0;
		end else begin
			unique case (eng_state)
				nvmac_pkg::ENG_IDLE: if (start_wr) begin
					wr_bit <= 1'b1;
					timer <= 16'(WRITE_CYCLES - 1);
					eng_state <= wr_long ? nvmac_pkg::ENG_WRITE : nvmac_pkg::ENG_SHORT;
				end
				nvmac_pkg::ENG_SHORT: begin
					wr_bit <= 1'b0;
					eng_state <= nvmac_pkg::ENG_IDLE;
				end
				nvmac_pkg::ENG_WRITE: if (timer == 16'h0000) begin
					wr_bit <= 1'b0;
					eng_state <= nvmac_pkg::ENG_IDLE;
				end else begin
					timer <= timer - 16'h0001;
				end
			endcase
		end
	end

	wire write_finish = eng_state == nvmac_pkg::ENG_WRITE && timer == 16'h0000 && !soft_reset_event;
	wire short_finish = eng_state == nvmac_pkg::ENG_SHORT && !soft_reset_event;

	// Done flag: a finishing write wins over a software clear in the same cycle.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			done_flag <= 1'b0;
		end else if (write_finish || short_finish) begin
			done_flag <= 1'b1;
		end else if (hit(reg_addr, `NVMAC_ADDR_FLAGS_TWO)) begin
			done_flag <= reg_wdata[`NVMAC_BIT_DONE];
		end
	end

	// Read strobe lives one cycle; data lands in the data registers at the same edge.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rd_bit <= 1'b0;
		end else begin
			rd_bit <= start_rd;
		end
	end

	// Address and data registers are not touched by the soft reset, preserving them after an abort.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			data_low <= 8'h00;
			data_high <= 8'h00;
			addr_low <= 8'h00;
			addr_high <= 8'h00;
		end else if (start_rd) begin
			data_low <= space ? prog_mem[prog_addr][7:0] : data_mem[addr_low];
			data_high <= space ? {2'h0, prog_mem[prog_addr][13:8]} : data_high;
		end else begin
			if (hit(reg_addr, `NVMAC_ADDR_DATA_LOW)) data_low <= reg_wdata;
			if (hit(reg_addr, `NVMAC_ADDR_DATA_HIGH)) data_high <= {2'h0, reg_wdata[5:0]};
			if (hit(reg_addr, `NVMAC_ADDR_ADDR_LOW)) addr_low <= reg_wdata;
			if (hit(reg_addr, `NVMAC_ADDR_ADDR_HIGH)) addr_high <= {3'h0, reg_wdata[4:0]};
		end
	end

	// Arrays: data byte overwrites in place (implicit erase); flash latches words, commits on the last.
	always_ff @(posedge clock) begin
		if (eng_state == nvmac_pkg::ENG_IDLE && start_wr && space && !row_erase) begin
			prog_buf[prog_addr[1:0]] <= {data_high[5:0], data_low};
		end
		if (write_finish && !space && data_addr_ok) begin
			data_mem[addr_low] <= data_low;
		end
		if (write_finish && space && row_erase) begin
			for (int i = 0; i < 32; i++) begin
				prog_mem[{prog_addr[11:5], 5'(i)}] <= 14'h3FFF;
			end
		end else if (write_finish && space) begin
			for (int i = 0; i < 3; i++) begin
				prog_mem[{prog_addr[11:2], 2'(i)}] <= prog_buf[i];
			end
			prog_mem[{prog_addr[11:2], 2'h3}] <= {data_high[5:0], data_low};
		end
	end

	assign pump_on = eng_state == nvmac_pkg::ENG_WRITE && (space || data_addr_ok);
	assign core_stall = eng_state == nvmac_pkg::ENG_WRITE && space;

	always_comb begin
		reg_rdata = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`NVMAC_ADDR_CONTROL: reg_rdata = ctrl_view;
				`NVMAC_ADDR_DATA_LOW: reg_rdata = data_low;
				`NVMAC_ADDR_DATA_HIGH: reg_rdata = data_high;
				`NVMAC_ADDR_ADDR_LOW: reg_rdata = addr_low;
				`NVMAC_ADDR_ADDR_HIGH: reg_rdata = addr_high;
				`NVMAC_ADDR_FLAGS_TWO: reg_rdata = {3'h0, done_flag, 4'h0};
				default: reg_rdata = 8'h00;
			endcase
		end
	end

	// A long write: the start edge, then the engine in its timed state.
	sequence start_seq;
		start_wr ##1 (eng_state == nvmac_pkg::ENG_WRITE);
	endsequence

	// A short program write ends one cycle after it begins.
	sequence short_seq;
		(eng_state == nvmac_pkg::ENG_SHORT) ##1 !wr_bit;
	endsequence

	// A read start raises the read bit for exactly the following cycle.
	sequence read_seq;
		start_rd ##1 rd_bit;
	endsequence

	// A row erase runs the same timed path as a long write and stalls the core.
	sequence row_erase_seq;
		(start_wr && space && row_erase) ##1 (eng_state == nvmac_pkg::ENG_WRITE);
	endsequence

	// Start gating: the key and the permit must both be in place one edge earlier.
	permit_gate_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(wr_bit) |-> $past(permit)) else $error("write started without permit");

	key_order_a: assert property (@(posedge clock) disable iff (!rstn)
		$rose(wr_bit) |-> $past(key_state) == nvmac_pkg::KEY_ARMED) else $error("write started without key");

	key_drop_a: assert property (@(posedge clock) disable iff (!rstn)
		key_state != nvmac_pkg::KEY_IDLE && reg_wr && !wr_key |=> key_state == nvmac_pkg::KEY_IDLE)
		else $error("unlock tracker kept state");

	// Completion flag behaviour.
	done_sticky_a: assert property (@(posedge clock) disable iff (!rstn)
		done_flag && !hit(reg_addr, `NVMAC_ADDR_FLAGS_TWO) |=> done_flag) else $error("done flag dropped");

	done_set_a: assert property (@(posedge clock) disable iff (!rstn)
		write_finish |=> done_flag && !wr_bit) else $error("done flag not set");

	done_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		hit(reg_addr, `NVMAC_ADDR_FLAGS_TWO) && !reg_wdata[`NVMAC_BIT_DONE] && !write_finish && !short_finish
		|=> !done_flag) else $error("done flag not cleared");

	done_view_a: assert property (@(posedge clock) disable iff (!rstn)
		reg_rd && reg_addr == `NVMAC_ADDR_FLAGS_TWO |-> reg_rdata[4] == done_flag && reg_rdata[3:0] == 4'h0)
		else $error("flags two read wrong");

	// Timing of the engine; a soft reset cuts the cycle short on purpose.
	timer_len_a: assert property (@(posedge clock) disable iff (!rstn || soft_reset_event)
		start_seq |-> ##39 wr_bit ##1 !wr_bit) else $error("write cycle length wrong");

	erase_len_a: assert property (@(posedge clock) disable iff (!rstn || soft_reset_event)
		row_erase_seq |-> core_stall ##39 wr_bit ##1 !wr_bit) else $error("row erase length wrong");

	wr_hold_a: assert property (@(posedge clock) disable iff (!rstn)
		eng_state == nvmac_pkg::ENG_WRITE && timer != 16'h0000 && !soft_reset_event |=> wr_bit)
		else $error("write bit dropped early");

	short_write_a: assert property (@(posedge clock) disable iff (!rstn)
		start_wr && space && !wr_long && !soft_reset_event |=> short_seq) else $error("short write did not end");

	pump_gate_a: assert property (@(posedge clock) disable iff (!rstn)
		pump_on |-> wr_bit) else $error("pump on without a write");

	data_write_a: assert property (@(posedge clock) disable iff (!rstn)
		write_finish && !space |=> data_mem[$past(addr_low)] == $past(data_low)) else $error("data byte not stored");

	// Register views and persistence.
	key_read_a: assert property (@(posedge clock) disable iff (!rstn)
		reg_rd && reg_addr == `NVMAC_ADDR_KEY |-> reg_rdata == 8'h00) else $error("key port not zero");

	abort_set_a: assert property (@(posedge clock) disable iff (!rstn)
		soft_reset_event && eng_state != nvmac_pkg::ENG_IDLE |=> abort) else $error("abort not flagged");

	regs_keep_a: assert property (@(posedge clock) disable iff (!rstn)
		soft_reset_event && !reg_wr |=> addr_low == $past(addr_low) && data_low == $past(data_low))
		else $error("registers lost on soft reset");

	permit_keep_a: assert property (@(posedge clock) disable iff (!rstn)
		!wr_ctrl |=> permit == $past(permit)) else $error("permit changed by hardware");

	reserved_zero_a: assert property (@(posedge clock) disable iff (!rstn)
		reg_rd && reg_addr == `NVMAC_ADDR_CONTROL |-> reg_rdata[6:5] == 2'h0) else $error("reserved bits set");

	space_view_a: assert property (@(posedge clock) disable iff (!rstn)
		reg_rd && reg_addr == `NVMAC_ADDR_CONTROL |-> reg_rdata[7] == space) else $error("space bit read wrong");

	// Read strobe: one cycle high, then low again.
	read_pulse_a: assert property (@(posedge clock) disable iff (!rstn)
		start_rd |-> read_seq) else $error("read bit not raised");

	read_clear_a: assert property (@(posedge clock) disable iff (!rstn)
		rd_bit |=> !rd_bit) else $error("read bit stuck");

	read_data_a: assert property (@(posedge clock) disable iff (!rstn)
		start_rd && !space |=> data_low == $past(data_mem[addr_low])) else $error("read data not loaded");
endmodule
`default_nettype wire

// ===== core/nvmac_cfg.svh
// Purpose: Register offsets, field positions and timing counts for the nonvolatile access controller.
// Assumes: Core instruction clock of 10 MHz.
// Notes: Definitions only.
`ifndef NVMAC_CFG_SVH
`define NVMAC_CFG_SVH
`define NVMAC_ADDR_CONTROL 9'h18C
`define NVMAC_ADDR_KEY 9'h18D
`define NVMAC_ADDR_DATA_LOW 9'h10C
`define NVMAC_ADDR_DATA_HIGH 9'h10E
`define NVMAC_ADDR_ADDR_LOW 9'h10D
`define NVMAC_ADDR_ADDR_HIGH 9'h10F
`define NVMAC_ADDR_FLAGS_TWO 9'h00D
`define NVMAC_BIT_RD 0
`define NVMAC_BIT_WR 1
`define NVMAC_BIT_PERMIT 2
`define NVMAC_BIT_ABORT 3
`define NVMAC_BIT_ROW_ERASE 4
`define NVMAC_BIT_SPACE 7
`define NVMAC_BIT_DONE 4
`define NVMAC_KEY_FIRST 8'h55
`define NVMAC_KEY_SECOND 8'hAA
`define NVMAC_WRITE_TIME_US 4
`define NVMAC_CLOCK_MHZ 10
`define NVMAC_WRITE_CYCLES (`NVMAC_WRITE_TIME_US * `NVMAC_CLOCK_MHZ)
`endif

// ===== core/nvmac_pkg.sv
// Purpose: Types shared by the nonvolatile access controller.
// Assumes: Nothing beyond the configuration header.
// Notes: States of the unlock tracker and of the write engine.
package nvmac_pkg;
	typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} nvmac_key_t;
	typedef enum logic [1:0] {ENG_IDLE, ENG_WRITE, ENG_SHORT} nvmac_eng_t;
endpackage

// ===== tb/nvmac_core_model.sv
// Purpose: Core software model that issues register accesses.
// Assumes: Writes are one-cycle strobes taken at the rising edge.
// Notes: An idle data bus shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module nvmac_core_model (
	input wire logic clock,
	input wire logic [7:0] reg_rdata,
	output logic reg_wr = 1'b0,
	output logic reg_rd = 1'b0,
	output logic [8:0] reg_addr = 9'h000,
	output logic [7:0] reg_wdata = 8'h00
);
	task automatic put(input logic [8:0] a, input logic [7:0] d);
		@(negedge clock);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b10, a, d};
		@(posedge clock);
	endtask
	// Reads settle combinationally, so sampling just after the falling edge is safe.
	task automatic get(input logic [8:0] a, output logic [7:0] d);
		@(negedge clock);
		{reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b01, a, ~reg_wdata};
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ===== tb/tb_nvmac_ctrl.sv
// Purpose: Self-checking bench for the nonvolatile access controller.
// Assumes: All register traffic goes through the core model on the falling edge.
// Notes: The write time is the design's fixed count of cycles.
`include "nvmac_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_nvmac_ctrl;
	localparam logic [8:0] ct = `NVMAC_ADDR_CONTROL;
	localparam logic [8:0] dl = `NVMAC_ADDR_DATA_LOW;
	localparam logic [8:0] al = `NVMAC_ADDR_ADDR_LOW;
	localparam logic [8:0] f2 = `NVMAC_ADDR_FLAGS_TWO;
	logic clock = 1'b0, rstn = 1'b0, soft_reset_event = 1'b0;
	logic reg_wr, reg_rd, core_stall, pump_on;
	logic [8:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, v, a, d;
	int errors = 0, total_checks = 0, n;
	always #50 clock = ~clock;
	nvmac_core_model i_nvmac_core_model (.clock(clock), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
	nvmac_ctrl i_nvmac_ctrl (.clock(clock), .rstn(rstn), .soft_reset_event(soft_reset_event),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .core_stall(core_stall), .pump_on(pump_on));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [8:0] r, input logic [7:0] m, input logic [7:0] exp);
		i_nvmac_core_model.get(r, v);
		chk(v & m, exp);
	endtask
	task automatic put(input logic [8:0] r, input logic [7:0] x);
		i_nvmac_core_model.put(r, x);
	endtask
	// Control byte from space, row erase, permit, write start and read start.
	function automatic logic [7:0] cb(input logic [4:0] f);
		return {f[4], 2'b00, f[3], 1'b0, f[2:0]};
	endfunction
	// Interrupts are taken as masked, so the keys go out back to back unless s inserts an address write between them.
	task automatic start(input logic [7:0] k, input logic s, input logic [4:0] f);
		put(ct, cb(f & 5'b11100));
		put(`NVMAC_ADDR_KEY, k);
		if (s)
			put(al, a);
		put(`NVMAC_ADDR_KEY, `NVMAC_KEY_SECOND);
		put(ct, cb(f));
	endtask
	// Software polls the write-start bit, with a bound, before going on.
	task automatic wait_idle;
		n = 0;
		do begin
			i_nvmac_core_model.get(ct, v);
			n++;
		end while (v[`NVMAC_BIT_WR] !== 1'b0 && n < 200);
	endtask
	task summarize;
		if (errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		summarize();
	end
	initial begin
		void'($urandom(32'h28FFDE2D));
		repeat (6) @(posedge clock);
		@(negedge clock);
		rstn = 1'b1;
		rchk(ct, 8'hFF, 8'h00);
		rchk(`NVMAC_ADDR_KEY, 8'hFF, 8'h00);
		for (int i = 0; i < 4; i++) begin
			a = (i == 0) ? 8'hFF : 8'($urandom());
			d = 8'($urandom());
			put(al, a);
			put(dl, d);
			start(`NVMAC_KEY_FIRST, 1'b0, 5'b00110);
			rchk(ct, 8'h02, 8'h02);
			chk({7'h00, pump_on}, 8'h01);
			put(ct, 8'h00);
			rchk(ct, 8'h06, 8'h02);
			wait_idle();
			chk(8'(n > 30 && n < 45), 8'h01);
			rchk(f2, 8'hFF, 8'h10);
			put(f2, 8'h00);
			rchk(f2, 8'h10, 8'h00);
			put(dl, ~d);
			put(ct, cb(5'b00001));
			rchk(dl, 8'hFF, d);
		end
		for (int k = 0; k < 3; k++) begin
			start((k == 0) ? 8'h5A : `NVMAC_KEY_FIRST, k == 1, (k == 2) ? 5'b00010 : 5'b00110);
			rchk(ct, 8'h02, 8'h00);
		end
		rchk(f2, 8'h10, 8'h00);
		start(`NVMAC_KEY_FIRST, 1'b0, 5'b00110);
		rchk(ct, 8'h02, 8'h02);
		@(negedge clock);
		soft_reset_event = 1'b1;
		@(negedge clock);
		soft_reset_event = 1'b0;
		rchk(ct, 8'h0E, 8'h0C);
		rchk(dl, 8'hFF, d);
		rchk(al, 8'hFF, a);
		put(`NVMAC_ADDR_ADDR_HIGH, 8'h10);
		put(al, 8'h03);
		put(dl, 8'h5C);
		put(`NVMAC_ADDR_DATA_HIGH, 8'h2A);
		start(`NVMAC_KEY_FIRST, 1'b0, 5'b10110);
		rchk(ct, 8'h82, 8'h82);
		chk({7'h00, core_stall}, 8'h01);
		wait_idle();
		put(`NVMAC_ADDR_ADDR_HIGH, 8'h00);
		put(ct, cb(5'b10001));
		rchk(ct, 8'h80, 8'h80);
		rchk(dl, 8'hFF, 8'h5C);
		rchk(`NVMAC_ADDR_DATA_HIGH, 8'h3F, 8'h2A);
		summarize();
	end
endmodule
`default_nettype wire
